// *** src/dc_output_policy.sv ***
// dc output policy, alarm routing and switch-off sequencing with apb registers
// assumes: alarms, mains switch and analog inputs are synchronous to CLK_SYS
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module dc_output_policy
    import psu_policy_pkg::*;
#(
    parameter int FAN_DELAY_TICKS = FAN_DELAY_US / TICK_US,
    parameter int POWERDOWN_TICKS = POWERDOWN_DELAY_US / TICK_US,
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic MAINS_SWITCH_OFF,
    input wire logic POWER_FAIL_ALARM,
    input wire logic OVERTEMP_ALARM,
    input wire logic OVERVOLTAGE_ALARM,
    input wire logic OVERCURRENT_ALARM,
    input wire logic OVERPOWER_ALARM,
    input wire logic CONSTANT_VOLTAGE_REGULATION,
    input wire logic REMOTE_STANDBY_INPUT,
    input wire logic DIGITAL_REMOTE_ON,
    input wire logic DIGITAL_REMOTE_OFF,
    input wire logic NV_SAVED_ON,
    output logic DC_OUTPUT_ON,
    output logic REMOTE_STATUS,
    output logic ANALOG_RANGE_10V,
    output logic ALARM_PIN_1,
    output logic ALARM_PIN_2,
    output logic STATUS_PIN,
    output logic NV_STORE,
    output logic NV_STORE_ON,
    output logic FANS_ON,
    output logic POWER_HOLD,
    output logic IRQ
);
    import psu_policy_pkg::*;

    // ====================================================================
    // registers and state
    logic [CFG_W-1:0] cfg;
    logic [EV_W-1:0] event_flags;
    logic [EV_W-1:0] event_mask;
    logic dc_on;
    logic saved_on;
    logic pre_ot_on;
    logic pre_pf_on;
    logic on_elsewhere;
    logic sb_prev;
    logic mains_prev;
    logic pf_prev;
    logic ot_prev;
    logic ov_prev;
    logic oc_prev;
    logic op_prev;
    logic started;
    logic pre_off_on;
    logic [31:0] timer;
    off_state_t state;
    off_state_t next_state;
    logic [31:0] rdata;
    logic tick;

    tick_divider #(.DIV(TICK_DIV)) u_tick (
        .clk(CLK_SYS),
        .rst(RST),
        .tick(tick)
    );

    // ====================================================================
    // apb decode
    wire access = PSEL & PENABLE;
    wire wr = access & PWRITE;
    wire rd = access & ~PWRITE;
    wire hit_cfg = (PADDR == ADDR_CONFIG);
    wire hit_ctl = (PADDR == ADDR_CONTROL);
    wire hit_sts = (PADDR == ADDR_STATUS);
    wire hit_ev = (PADDR == ADDR_EVENT);
    wire hit_mask = (PADDR == ADDR_MASK);
    wire hit_saved = (PADDR == ADDR_SAVED);
    wire mapped = hit_cfg | hit_ctl | hit_sts | hit_ev | hit_mask | hit_saved;
    // config refused while output is on
    wire cfg_locked = dc_on;
    wire cfg_write = wr & hit_cfg & ~cfg_locked;
    wire ctl_write = wr & hit_ctl;
    wire ev_read = rd & hit_ev;

    // ====================================================================
    // remote standby handling
    wire allow_remote = cfg[CFG_ALLOW_REMOTE];
    wire sb_level = REMOTE_STANDBY_INPUT ^ cfg[CFG_SB_INVERT];
    // level high after polarity means standby: output to go off
    wire sb_rise = sb_level & ~sb_prev;
    wire sb_fall = ~sb_level & sb_prev;
    wire sb_off_req = allow_remote & sb_rise;
    wire sb_on_req = allow_remote & cfg[CFG_SB_AUTO] & sb_fall & on_elsewhere;

    // ====================================================================
    // on and off requests from other locations
    wire local_on = ctl_write & PWDATA[CTL_ON];
    wire local_off = ctl_write & PWDATA[CTL_OFF];
    wire dig_on = allow_remote & DIGITAL_REMOTE_ON;
    wire dig_off = allow_remote & DIGITAL_REMOTE_OFF;
    wire other_on = local_on | dig_on;

    // ====================================================================
    // alarm edges and recovery
    wire pf_rise = POWER_FAIL_ALARM & ~pf_prev;
    wire pf_fall = ~POWER_FAIL_ALARM & pf_prev;
    wire ot_rise = OVERTEMP_ALARM & ~ot_prev;
    wire ot_fall = ~OVERTEMP_ALARM & ot_prev;
    wire mains_rise = MAINS_SWITCH_OFF & ~mains_prev;
    wire any_trip = POWER_FAIL_ALARM | OVERTEMP_ALARM | OVERVOLTAGE_ALARM
        | OVERCURRENT_ALARM | OVERPOWER_ALARM;
    wire ot_restore = ot_fall & cfg[CFG_OT_AUTO] & pre_ot_on;
    wire pf_restore = pf_fall & cfg[CFG_PF_AUTO] & pre_pf_on;
    wire running = (state == ST_RUN);
    // mains level in the term so the output drops on the very edge that sees it
    wire force_off = any_trip | ~running | MAINS_SWITCH_OFF | sb_off_req
        | local_off | dig_off;
    wire want_on = other_on | sb_on_req | ot_restore | pf_restore;
    wire next_dc_on = force_off ? 1'b0 : (want_on | dc_on);

    // ====================================================================
    // event capture: set wins over read-clear
    wire [EV_W-1:0] ev_set = {
        (state == ST_FAN) & (next_state == ST_DOWN),
        OVERPOWER_ALARM & ~op_prev,
        OVERCURRENT_ALARM & ~oc_prev,
        OVERVOLTAGE_ALARM & ~ov_prev,
        ot_rise,
        pf_rise | mains_rise
    };
    // read clears only what PRDATA showed, so a flag set during setup is kept
    wire [EV_W-1:0] read_clear = ev_read ? PRDATA[EV_W-1:0] : {EV_W{1'b0}};
    wire [EV_W-1:0] next_events = (event_flags & ~read_clear) | ev_set;

    // ====================================================================
    // switch-off sequence
    wire timer_done_fan = tick & (timer >= 32'(FAN_DELAY_TICKS - 1));
    // saturates so the power hold stays released as a level
    wire timer_done_down = (state == ST_DOWN) & (timer >= 32'(POWERDOWN_TICKS));
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (mains_rise) begin
                    next_state = ST_SAVE;
                end
            end
            ST_SAVE: begin
                next_state = ST_FAN;
            end
            ST_FAN: begin
                if (timer_done_fan) begin
                    next_state = ST_DOWN;
                end
            end
            ST_DOWN: begin
                next_state = ST_DOWN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end
    wire timer_clear = (state != next_state);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state <= ST_RUN;
            timer <= 32'h0000_0000;
        end else begin
            state <= next_state;
            if (timer_clear) begin
                timer <= 32'h0000_0000;
            end else if (tick && !timer_done_down) begin
                timer <= timer + 32'h0000_0001;
            end
        end
    end

    // ====================================================================
    // output state and memories of it
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            dc_on <= 1'b0;
            started <= 1'b0;
            saved_on <= 1'b0;
            pre_ot_on <= 1'b0;
            pre_pf_on <= 1'b0;
            on_elsewhere <= 1'b0;
        end else begin
            // saved state sampled after reset release, not at reset
            started <= 1'b1;
            if (!started) begin
                saved_on <= NV_SAVED_ON;
                dc_on <= cfg[CFG_PWRUP_RESTORE] & NV_SAVED_ON & ~force_off;
            end else begin
                dc_on <= next_dc_on;
            end
            if (ot_rise) begin
                pre_ot_on <= dc_on;
            end
            if (pf_rise) begin
                pre_pf_on <= dc_on;
            end
            if (other_on) begin
                on_elsewhere <= 1'b1;
            end else if (local_off | dig_off) begin
                on_elsewhere <= 1'b0;
            end
            if (state == ST_SAVE) begin
                saved_on <= pre_off_on;
            end
        end
    end

    // output condition just before the switch-off forced it low
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pre_off_on <= 1'b0;
        end else if (running) begin
            pre_off_on <= dc_on;
        end
    end

    // ====================================================================
    // edge history and software registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sb_prev <= 1'b0;
            mains_prev <= 1'b0;
            pf_prev <= 1'b0;
            ot_prev <= 1'b0;
            ov_prev <= 1'b0;
            oc_prev <= 1'b0;
            op_prev <= 1'b0;
            cfg <= CFG_RESET;
            event_flags <= {EV_W{1'b0}};
            event_mask <= {EV_W{1'b0}};
        end else begin
            sb_prev <= sb_level;
            mains_prev <= MAINS_SWITCH_OFF;
            pf_prev <= POWER_FAIL_ALARM;
            ot_prev <= OVERTEMP_ALARM;
            ov_prev <= OVERVOLTAGE_ALARM;
            oc_prev <= OVERCURRENT_ALARM;
            op_prev <= OVERPOWER_ALARM;
            event_flags <= next_events;
            if (cfg_write) begin
                cfg <= PWDATA[CFG_W-1:0];
            end
            if (wr && hit_mask) begin
                event_mask <= PWDATA[EV_W-1:0];
            end
        end
    end

    // ====================================================================
    // read mux
    wire [31:0] status_word = {26'h0000000, ~running, CONSTANT_VOLTAGE_REGULATION,
        allow_remote, cfg_locked, on_elsewhere, dc_on};
    assign rdata = hit_cfg ? {19'h00000, cfg}
        : hit_sts ? status_word
        : hit_ev ? {26'h0000000, event_flags}
        : hit_mask ? {26'h0000000, event_mask}
        : hit_saved ? {31'h00000000, saved_on}
        : 32'h0000_0000;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rdata;
        end
    end
    assign PREADY = 1'b1;
    // unmapped addresses and locked config writes answer with an error
    assign PSLVERR = access & (~mapped | (wr & hit_cfg & cfg_locked));

    // ====================================================================
    // pins
    wire pin1 = (cfg[CFG_P1_OT] & OVERTEMP_ALARM)
        | (cfg[CFG_P1_PF] & POWER_FAIL_ALARM);
    wire pin2 = (cfg[CFG_P2_OV] & OVERVOLTAGE_ALARM)
        | (cfg[CFG_P2_OC] & OVERCURRENT_ALARM)
        | (cfg[CFG_P2_OP] & OVERPOWER_ALARM);
    wire pin3 = cfg[CFG_P3_DC] ? dc_on : CONSTANT_VOLTAGE_REGULATION;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ALARM_PIN_1 <= 1'b0;
            ALARM_PIN_2 <= 1'b0;
            STATUS_PIN <= 1'b0;
        end else begin
            ALARM_PIN_1 <= pin1;
            ALARM_PIN_2 <= pin2;
            STATUS_PIN <= pin3;
        end
    end
    assign DC_OUTPUT_ON = dc_on;
    assign REMOTE_STATUS = allow_remote;
    assign ANALOG_RANGE_10V = cfg[CFG_RANGE_10V];
    assign NV_STORE = (state == ST_SAVE);
    assign NV_STORE_ON = pre_off_on;
    assign FANS_ON = (state == ST_RUN) | (state == ST_SAVE) | (state == ST_FAN);
    assign POWER_HOLD = ~timer_done_down;
    assign IRQ = |(event_flags & event_mask);
endmodule : dc_output_policy

// *** src/psu_policy_pkg.sv ***
// package: offsets, field layouts, reset values and timing for the dc output policy block
// assumes: one 125 MHz clock, registers reached over apb with 32-bit data
// Function
// - at switch-off, save output on/off state and set values to nonvolatile store; only the on/off state is stored here
// - a normal switch-off also raises a power-fail alarm event
// - switch-off: output off at once, fans stop after delay, power-down later
// - configuration writable only while output disabled; else status only
// - remote control disallowed: ignore digital and analog control, report local
// - range setting selects 0-5 V or 0-10 V analog span
// - remote-standby polarity: normal, or levels and function inverted
// - off-only action: remote-standby may only disable the output
// - auto action: standby disables and re-enables, only if enabled elsewhere before
// - alarm pin one: overtemp and power-fail by default, each maskable
// - alarm pin two: overvoltage by default; ov, oc, op each selectable
// - status pin: constant-voltage by default, or output on/off state
// - after overtemp clears: stay off, or restore pre-alarm state in auto
// - power-up: output off, or restore the saved on/off condition; here cfg resets with the restore bit clear, so output stays off
// - after power-fail: hold off until user, or auto re-enable if on before
// - power-fail detected: stop delivering power, disable output
// - overcurrent alarm disables the output
// - overpower alarm disables the output
package psu_policy_pkg;
    // ====================================================================
    // register map
    localparam logic [11:0] ADDR_CONFIG = 12'h000;
    localparam logic [11:0] ADDR_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_EVENT = 12'h00c;
    localparam logic [11:0] ADDR_MASK = 12'h010;
    localparam logic [11:0] ADDR_SAVED = 12'h014;
    // ====================================================================
    // config fields
    localparam int CFG_ALLOW_REMOTE = 0;
    localparam int CFG_RANGE_10V = 1;
    localparam int CFG_SB_INVERT = 2;
    localparam int CFG_SB_AUTO = 3;
    localparam int CFG_P1_OT = 4;
    localparam int CFG_P1_PF = 5;
    localparam int CFG_P2_OV = 6;
    localparam int CFG_P2_OC = 7;
    localparam int CFG_P2_OP = 8;
    localparam int CFG_P3_DC = 9;
    localparam int CFG_OT_AUTO = 10;
    localparam int CFG_PWRUP_RESTORE = 11;
    localparam int CFG_PF_AUTO = 12;
    localparam int CFG_W = 13;
    localparam logic [12:0] CFG_RESET = 13'h0071;
    // ====================================================================
    // event bits
    localparam int EV_PF = 0;
    localparam int EV_OT = 1;
    localparam int EV_OV = 2;
    localparam int EV_OC = 3;
    localparam int EV_OP = 4;
    localparam int EV_OFF_DONE = 5;
    localparam int EV_W = 6;
    // ====================================================================
    // control bits: 0 = output on request, 1 = output off request
    localparam int CTL_ON = 0;
    localparam int CTL_OFF = 1;
    // ====================================================================
    // timing
    localparam int CLK_MHZ = 125;
    localparam int FAN_DELAY_MS = 500;
    localparam int POWERDOWN_DELAY_MS = 3000;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int FAN_DELAY_US = FAN_DELAY_MS * 1000;
    localparam int POWERDOWN_DELAY_US = POWERDOWN_DELAY_MS * 1000;
    // ====================================================================
    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_SAVE = 4'b0010,
        ST_FAN = 4'b0100,
        ST_DOWN = 4'b1000
    } off_state_t;
endpackage : psu_policy_pkg

// *** src/tick_divider.sv ***
// tick divider: one-cycle enable every DIV clocks
// assumes: single clock domain
`timescale 1ns/1ps
module tick_divider #(
    parameter int DIV = 125
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    logic [15:0] count;
    wire last = (count == 16'(DIV - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 16'h0000;
        end else begin
            count <= last ? 16'h0000 : count + 16'h0001;
        end
    end
    assign tick = last;
endmodule : tick_divider

// *** verification/dc_output_policy_tb_top.sv ***
// testbench: apb-driven sequences against the dc output policy
// assumes: psu_policy_pkg compiled first; short tick counts set below
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module dc_output_policy_tb_top;
    import psu_policy_pkg::*;
    logic clk, rst, psel, penable, pwrite, mains, cv, sb, d_on, d_off, nv_on;
    logic pready, pslverr, err, dc, rs, r10, pin1, pin2, spin, nvs, nvd, fans, hold, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [4:0] alm;
    int n_mismatch, checked;
    dc_output_policy #(.FAN_DELAY_TICKS(4), .POWERDOWN_TICKS(8), .TICK_DIV(2)) uut (
        .CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .MAINS_SWITCH_OFF(mains), .POWER_FAIL_ALARM(alm[EV_PF]), .OVERTEMP_ALARM(alm[EV_OT]),
        .OVERVOLTAGE_ALARM(alm[EV_OV]), .OVERCURRENT_ALARM(alm[EV_OC]),
        .OVERPOWER_ALARM(alm[EV_OP]), .CONSTANT_VOLTAGE_REGULATION(cv),
        .REMOTE_STANDBY_INPUT(sb), .DIGITAL_REMOTE_ON(d_on), .DIGITAL_REMOTE_OFF(d_off),
        .NV_SAVED_ON(nv_on), .DC_OUTPUT_ON(dc), .REMOTE_STATUS(rs), .ANALOG_RANGE_10V(r10),
        .ALARM_PIN_1(pin1), .ALARM_PIN_2(pin2), .STATUS_PIN(spin), .NV_STORE(nvs),
        .NV_STORE_ON(nvd), .FANS_ON(fans), .POWER_HOLD(hold), .IRQ(irq));
    nv_store_model nv (.clk(clk), .store(nvs), .store_on(nvd), .saved_on(nv_on));
    // ==========================================
    // bus and run control
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no wait-state count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask : tk
    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // run is under 1k cycles; the limit leaves a wide margin
    initial begin
        #100000;
        n_mismatch++;
        stop_test;
    end
    // ==========================================
    // scenarios
    initial begin
        {rst, psel, penable, pwrite, mains, cv, sb, d_on, d_off, alm} = {9'h100, 5'h0};
        paddr = 12'h000;
        pwdata = 32'h0;
        tk(10);
        rst <= 1'b0;
        tk(1);
        apb(0, ADDR_CONFIG, 0);
        `CHK(rdata[12:0], CFG_RESET)
        `CHK({dc, rs, fans, hold, r10}, 5'b01110)
        apb(0, 12'h020, 0);
        `CHK(err, 1'b1)
        apb(1, ADDR_CONTROL, 32'h1);
        apb(1, ADDR_CONFIG, 32'h73);
        `CHK({dc, err}, 2'b11)
        apb(0, ADDR_STATUS, 0);
        `CHK(rdata[5:0], 6'h0f)
        apb(0, ADDR_CONFIG, 0);
        `CHK(rdata[12:0], 13'h0071)
        apb(1, ADDR_CONTROL, 32'h3);
        apb(1, ADDR_CONFIG, 32'h73);
        `CHK({dc, err, r10}, 3'b001)
        apb(1, ADDR_CONFIG, 32'h70);
        d_on <= 1'b1;
        tk(1);
        d_on <= 1'b0;
        tk(2);
        `CHK({dc, rs}, 2'b00)
        apb(1, ADDR_CONTROL, 32'h1);
        sb <= 1'b1;
        tk(3);
        `CHK(dc, 1'b1)
        sb <= 1'b0;
        apb(1, ADDR_CONTROL, 32'h2);
        // off-only, auto, auto with inverted input
        for (int m = 0; m < 3; m++) begin
            apb(1, ADDR_CONFIG, m == 0 ? 32'h71 : (m == 1 ? 32'h79 : 32'h7d));
            sb <= (m == 2);
            d_on <= 1'b1;
            tk(1);
            d_on <= 1'b0;
            tk(2);
            `CHK(dc, 1'b1)
            sb <= (m != 2);
            tk(3);
            `CHK(dc, 1'b0)
            sb <= (m == 2);
            tk(3);
            `CHK(dc, m != 0)
            d_off <= 1'b1;
            tk(1);
            d_off <= 1'b0;
            tk(2);
        end
        cv <= 1'b1;
        tk(3);
        `CHK(spin, 1'b1)
        apb(1, ADDR_CONFIG, 32'h271);
        tk(2);
        `CHK(spin, 1'b0)
        apb(1, ADDR_CONTROL, 32'h1);
        tk(3);
        `CHK(spin, 1'b1)
        apb(1, ADDR_CONTROL, 32'h2);
        // k selects power fail or overtemp
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 2; k++) begin
                apb(1, ADDR_CONFIG, m ? 32'h1471 : 32'h71);
                apb(1, ADDR_CONTROL, 32'h1);
                alm[k] <= 1'b1;
                tk(3);
                `CHK(dc, 1'b0)
                alm <= '0;
                tk(3);
                `CHK(dc, m[0])
                apb(1, ADDR_CONTROL, 32'h2);
            end
        end
        for (int k = 2; k < 5; k++) begin
            apb(1, ADDR_CONTROL, 32'h1);
            alm[k] <= 1'b1;
            tk(3);
            `CHK(dc, 1'b0)
            alm <= '0;
        end
        for (int c = 0; c < 32; c++) begin
            apb(1, ADDR_CONFIG, 32'h1 | (c << 4));
            for (int k = 0; k < 5; k++) begin
                alm <= 5'(1 << k);
                tk(3);
                `CHK(pin1, k < 2 && c[1 - k])
                `CHK(pin2, k >= 2 && c[k])
            end
            alm <= '0;
        end
        apb(0, ADDR_EVENT, 0);
        apb(1, ADDR_MASK, 0);
        apb(1, ADDR_CONTROL, 32'h1);
        mains <= 1'b1;
        tk(3);
        `CHK({dc, fans, hold, irq}, 4'b0110)
        tk(15);
        `CHK({fans, hold}, 2'b01)
        apb(1, ADDR_MASK, 32'h1);
        `CHK(irq, 1'b1)
        apb(0, ADDR_EVENT, 0);
        `CHK(rdata[EV_PF], 1'b1)
        `CHK(rdata[EV_OFF_DONE], 1'b1)
        tk(1);
        `CHK(irq, 1'b0)
        tk(30);
        `CHK({fans, hold, nv_on}, 3'b001)
        mains <= 1'b0;
        rst <= 1'b1;
        tk(2);
        rst <= 1'b0;
        tk(3);
        `CHK({dc, nv_on}, 2'b01)
        apb(0, ADDR_SAVED, 0);
        `CHK(rdata[0], 1'b1)
        stop_test;
    end
endmodule : dc_output_policy_tb_top

// *** verification/dc_policy_props.sv ***
// checker: port-level properties of the dc output policy
// assumes: bound to dc_output_policy, one clock, async high reset
`timescale 1ns/1ps
module dc_policy_props (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic MAINS_SWITCH_OFF,
    input wire logic POWER_FAIL_ALARM,
    input wire logic OVERTEMP_ALARM,
    input wire logic OVERVOLTAGE_ALARM,
    input wire logic OVERCURRENT_ALARM,
    input wire logic OVERPOWER_ALARM,
    input wire logic DIGITAL_REMOTE_ON,
    input wire logic DC_OUTPUT_ON,
    input wire logic REMOTE_STATUS,
    input wire logic ALARM_PIN_1,
    input wire logic ALARM_PIN_2,
    input wire logic NV_STORE,
    input wire logic FANS_ON
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // ==========================================
    // shutdown paths
    pf_shutdown_a: assert property (POWER_FAIL_ALARM |=> !DC_OUTPUT_ON)
        else $error("output on after power fail");
    limit_shutdown_a: assert property (
        (OVERCURRENT_ALARM || OVERPOWER_ALARM) |=> !DC_OUTPUT_ON)
        else $error("output on after limit alarm");
    mains_off_a: assert property (MAINS_SWITCH_OFF |=> !DC_OUTPUT_ON)
        else $error("output on during switch-off");
    save_pulse_a: assert property ($rose(MAINS_SWITCH_OFF) |-> ##[1:3] NV_STORE)
        else $error("no store pulse at switch-off");
    fans_stop_a: assert property ($fell(FANS_ON) |-> MAINS_SWITCH_OFF && !DC_OUTPUT_ON)
        else $error("fans stopped outside switch-off");
    // ==========================================
    // alarm pins and remote gating
    pin_one_idle_a: assert property (!OVERTEMP_ALARM && !POWER_FAIL_ALARM |=> !ALARM_PIN_1)
        else $error("alarm pin one without source");
    pin_two_idle_a: assert property (
        !(OVERVOLTAGE_ALARM || OVERCURRENT_ALARM || OVERPOWER_ALARM) |=> !ALARM_PIN_2)
        else $error("alarm pin two without source");
    remote_ignore_a: assert property (DIGITAL_REMOTE_ON && !REMOTE_STATUS && !DC_OUTPUT_ON
        && !PSEL && !$past(OVERTEMP_ALARM) && !$past(POWER_FAIL_ALARM) |=> !DC_OUTPUT_ON)
        else $error("remote on taken while local");
endmodule : dc_policy_props

bind dc_output_policy dc_policy_props chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
    .MAINS_SWITCH_OFF(MAINS_SWITCH_OFF), .POWER_FAIL_ALARM(POWER_FAIL_ALARM),
    .OVERTEMP_ALARM(OVERTEMP_ALARM), .OVERVOLTAGE_ALARM(OVERVOLTAGE_ALARM),
    .OVERCURRENT_ALARM(OVERCURRENT_ALARM), .OVERPOWER_ALARM(OVERPOWER_ALARM),
    .DIGITAL_REMOTE_ON(DIGITAL_REMOTE_ON), .DC_OUTPUT_ON(DC_OUTPUT_ON),
    .REMOTE_STATUS(REMOTE_STATUS), .ALARM_PIN_1(ALARM_PIN_1), .ALARM_PIN_2(ALARM_PIN_2),
    .NV_STORE(NV_STORE), .FANS_ON(FANS_ON));

// *** verification/nv_store_model.sv ***
// partner: nonvolatile store that keeps the saved output state
// assumes: clocked by CLK_SYS, fed by the NV_STORE pulse and its data
`timescale 1ns/1ps
module nv_store_model (
    input wire logic clk,
    input wire logic store,
    input wire logic store_on,
    output logic saved_on
);
    // no reset on purpose: contents outlive a power cycle
    initial saved_on = 1'b0;
    always @(posedge clk) begin
        if (store === 1'b1) begin
            saved_on <= store_on;
        end
    end
endmodule : nv_store_model
